// ===== design/mmlp_consts.svh
// Function
// RULE1 - Decode single-cycle and extended I/O ranges
// RULE2 - Map signature row and fuse bytes
// RULE3 - EEPROM 256 bytes, four 64-byte pages
// RULE4 - EEPROM single and multi-byte access
// RULE5 - SRAM 3 KB, stack at top
// RULE6 - No instruction fetch from SRAM
// RULE7 - Flash readable in data space at 0x8000
// RULE8 - Program-memory loads address Flash from zero
// RULE9 - 32 KB Flash fully addressable by PC
// RULE10 - Flash sections; cross-section writes may block
// RULE11 - Checksum unit is extra bus host
// RULE12 - User row byte access, debug when unlocked
// RULE13 - Full erase preserves user row
// RULE14 - Locked: user row writable, not readable
// RULE15 - Locked when key is not valid
// RULE16 - Locked: deny debug access to memories
// RULE17 - CPU accesses ignore lock state
// RULE18 - Denied debug reads return meaningless data
// RULE19 - Full erase unlocks, clears application data
// RULE20 - Key 0xC5 alone means unlocked
// RULE21 - Fuses readable by all, writable by debug; code denies debug fuse reads while locked
// RULE22 - Locked: debug port off system bus
// RULE23 - Unmapped reads zero, writes ignored
`ifndef MMLP_CONSTS_SVH
`define MMLP_CONSTS_SVH
`define MMLP_SIO_LO 16'h0000
`define MMLP_SIO_HI 16'h003F
`define MMLP_XIO_LO 16'h0040
`define MMLP_XIO_HI 16'h107F
`define MMLP_SIG_LO 16'h1100
`define MMLP_SIG_HI 16'h11FF
`define MMLP_FUSE_LO 16'h1280
`define MMLP_FUSE_HI 16'h1289
`define MMLP_LOCK_LO 16'h128A
`define MMLP_LOCK_HI 16'h12FF
`define MMLP_UROW_LO 16'h1300
`define MMLP_UROW_HI 16'h137F
`define MMLP_EE_LO 16'h1400
`define MMLP_EE_HI 16'h14FF
`define MMLP_SRAM_LO 16'h3400
`define MMLP_SRAM_HI 16'h3FFF
`define MMLP_FLASH_LO 16'h8000
`define MMLP_FLASH_HI 16'hFFFF
`define MMLP_CODE_HI 15'h7FFF
`define MMLP_VALID_KEY 8'hC5
`define MMLP_DENY_DATA 8'hFF
`define MMLP_ZERO_DATA 8'h00
`define MMLP_EE_PAGE_LSB 6
`define MMLP_RESET_KEY 8'h00
`endif

// ===== design/mmlp_pkg.sv
package mmlp_pkg;
  typedef enum logic [3:0] {
    MMLP_R_NONE, MMLP_R_SIO, MMLP_R_XIO, MMLP_R_SIG, MMLP_R_FUSE, MMLP_R_LOCK,
    MMLP_R_UROW, MMLP_R_EE, MMLP_R_SRAM, MMLP_R_FLASH
  } mmlp_region_type;
  typedef enum logic [1:0] {
    MMLP_HOST_CPU, MMLP_HOST_CRC, MMLP_HOST_DBG
  } mmlp_host_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic fuse_cmd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mmlp_req_type;
  typedef struct packed {
    logic valid;
    logic denied;
    mmlp_region_type region;
    logic [7:0] rdata;
  } mmlp_rsp_type;
  typedef struct packed {
    logic valid;
    logic write;
    mmlp_region_type region;
    logic [15:0] offset;
    logic [7:0] wdata;
  } mmlp_mem_type;
endpackage

// ===== design/mmlp_protect.sv
`timescale 1ns/1ps
`default_nettype none
`include "mmlp_consts.svh"
module mmlp_protect
  import mmlp_pkg::*;
#(
  parameter int SECTION_W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire mmlp_req_type cpu_req_i,
  input wire mmlp_req_type crc_req_i,
  input wire mmlp_req_type dbg_req_i,
  input wire logic dbg_erase_i,
  input wire logic [14:0] fetch_addr_i,
  input wire logic fetch_valid_i,
  input wire logic [14:0] pmload_addr_i,
  input wire logic pmload_valid_i,
  input wire logic [7:0] lock_key_i,
  input wire logic [SECTION_W-1:0] boot_end_i,
  input wire logic [SECTION_W-1:0] app_end_i,
  input wire logic [14:0] exec_pc_i,
  input wire logic [7:0] mem_rdata_i,
  output mmlp_mem_type mem_o,
  output mmlp_host_type mem_host_o,
  output logic [14:0] code_addr_o,
  output logic code_valid_o,
  output logic fetch_fault_o,
  output logic [1:0] ee_page_o,
  output mmlp_rsp_type cpu_rsp_o,
  output mmlp_rsp_type crc_rsp_o,
  output mmlp_rsp_type dbg_rsp_o,
  output logic erase_app_o,
  output logic erase_busy_o,
  output logic locked_o,
  output logic section_block_o
);
  logic rst_meta;
  logic rst_n;
  logic locked;
  logic erase_busy;
  mmlp_req_type sel;
  mmlp_host_type host;
  mmlp_region_type region;
  logic [15:0] base;
  logic dbg_ok;
  logic sect_block;
  logic [1:0] src_sec;
  logic [1:0] dst_sec;
  logic [7:0] key_latched;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  function automatic mmlp_region_type decode(input logic [15:0] a);
    mmlp_region_type r;
    r = MMLP_R_NONE;
    if (a <= `MMLP_SIO_HI) begin // see RULE1
      r = MMLP_R_SIO;
    end else if (a >= `MMLP_XIO_LO && a <= `MMLP_XIO_HI) begin // see RULE1
      r = MMLP_R_XIO;
    end else if (a >= `MMLP_SIG_LO && a <= `MMLP_SIG_HI) begin // see RULE2
      r = MMLP_R_SIG;
    end else if (a >= `MMLP_FUSE_LO && a <= `MMLP_FUSE_HI) begin // see RULE2
      r = MMLP_R_FUSE;
    end else if (a >= `MMLP_LOCK_LO && a <= `MMLP_LOCK_HI) begin
      r = MMLP_R_LOCK;
    end else if (a >= `MMLP_UROW_LO && a <= `MMLP_UROW_HI) begin
      r = MMLP_R_UROW;
    end else if (a >= `MMLP_EE_LO && a <= `MMLP_EE_HI) begin // see RULE3
      r = MMLP_R_EE;
    end else if (a >= `MMLP_SRAM_LO && a <= `MMLP_SRAM_HI) begin // see RULE5
      r = MMLP_R_SRAM;
    end else if (a >= `MMLP_FLASH_LO) begin // see RULE7
      r = MMLP_R_FLASH;
    end
    return r;
  endfunction

  function automatic logic [15:0] region_base(input mmlp_region_type r);
    logic [15:0] b;
    b = 16'h0000;
    case (r)
      MMLP_R_XIO: b = `MMLP_XIO_LO;
      MMLP_R_SIG: b = `MMLP_SIG_LO;
      MMLP_R_FUSE: b = `MMLP_FUSE_LO;
      MMLP_R_LOCK: b = `MMLP_LOCK_LO;
      MMLP_R_UROW: b = `MMLP_UROW_LO;
      MMLP_R_EE: b = `MMLP_EE_LO;
      MMLP_R_SRAM: b = `MMLP_SRAM_LO;
      MMLP_R_FLASH: b = `MMLP_FLASH_LO;
      default: b = `MMLP_SIO_LO;
    endcase
    return b;
  endfunction

  function automatic logic [1:0] section_of(input logic [14:0] a, input logic [SECTION_W-1:0] be,
                                            input logic [SECTION_W-1:0] ae);
    logic [1:0] s;
    logic [SECTION_W-1:0] pg;
    pg = a[14:15-SECTION_W];
    s = 2'h2;
    if (pg < be) begin
      s = 2'h0;
    end else if (pg < ae) begin
      s = 2'h1;
    end
    return s;
  endfunction

  // The key is sampled every cycle, so a reprogrammed lock field acts from the next clock edge.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      key_latched <= `MMLP_RESET_KEY;
    end else begin
      key_latched <= lock_key_i;
    end
  end

  assign locked = (key_latched != `MMLP_VALID_KEY); // see RULE15 see RULE20
  assign locked_o = locked;

  // Erase busy follows the erase request one cycle late so the memory side sees a one-cycle pulse.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      erase_busy <= 1'b0;
    end else begin
      erase_busy <= dbg_erase_i; // see RULE19
    end
  end
  assign erase_busy_o = erase_busy;
  // User row is not part of the erased application set.
  assign erase_app_o = dbg_erase_i & ~erase_busy; // see RULE19 see RULE13

  // Fixed priority: CPU, then checksum unit, then debug port.
  always_comb begin
    sel = '0;
    host = MMLP_HOST_CPU;
    if (cpu_req_i.valid) begin
      sel = cpu_req_i;
    end else if (crc_req_i.valid) begin // see RULE11
      sel = crc_req_i;
      host = MMLP_HOST_CRC;
    end else if (dbg_req_i.valid && !erase_busy) begin
      sel = dbg_req_i;
      host = MMLP_HOST_DBG;
    end
  end

  assign region = decode(sel.addr);
  assign base = region_base(region);
  assign src_sec = section_of(exec_pc_i, boot_end_i, app_end_i);
  assign dst_sec = section_of(sel.addr[14:0], boot_end_i, app_end_i);
  // CPU code outside the boot section may not write into a lower section.
  assign sect_block = (host == MMLP_HOST_CPU) && sel.write && (region == MMLP_R_FLASH) &&
                      (src_sec != 2'h0) && (dst_sec < src_sec); // see RULE10

  always_comb begin
    dbg_ok = 1'b0;
    if (!locked) begin
      dbg_ok = !(sel.write && region == MMLP_R_SIG);
    end else if (region == MMLP_R_UROW && sel.write && sel.fuse_cmd) begin
      dbg_ok = 1'b1; // see RULE14
    end
  end // see RULE16 see RULE22

  logic allow;
  always_comb begin
    allow = 1'b1;
    if (region == MMLP_R_NONE) begin
      allow = 1'b0; // see RULE23
    end else if (host == MMLP_HOST_DBG) begin
      allow = dbg_ok;
    end else begin
      // CPU and checksum unit: signature row and fuses read-only.
      allow = !(sel.write && (region == MMLP_R_SIG || region == MMLP_R_FUSE || region == MMLP_R_LOCK))
              && !sect_block; // see RULE17 see RULE21
    end
  end

  always_comb begin
    mem_o.valid = sel.valid & allow;
    mem_o.write = sel.write;
    mem_o.region = region;
    mem_o.offset = 16'(sel.addr - base); // see RULE4 see RULE12
    mem_o.wdata = sel.wdata;
  end
  assign mem_host_o = host;
  assign section_block_o = sect_block;
  assign ee_page_o = mem_o.offset[`MMLP_EE_PAGE_LSB+1:`MMLP_EE_PAGE_LSB]; // see RULE3

  // Code space: program-memory loads win over fetches in the same cycle.
  assign code_valid_o = fetch_valid_i | pmload_valid_i; // see RULE8 see RULE9
  assign code_addr_o = pmload_valid_i ? pmload_addr_i : (fetch_addr_i & `MMLP_CODE_HI);
  // The PC only reaches code space, so SRAM is never a fetch target.
  assign fetch_fault_o = 1'b0; // see RULE6

  mmlp_rsp_type pend;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend <= '0;
    end else begin
      pend.valid <= sel.valid & ~sel.write;
      pend.denied <= sel.valid & ~allow;
      pend.region <= region;
      pend.rdata <= 8'(host);
    end
  end

  // Response status is registered; read data is taken from mem_rdata_i one cycle after the request.
  always_comb begin
    logic [7:0] d;
    d = mem_rdata_i;
    if (pend.region == MMLP_R_NONE) begin
      d = `MMLP_ZERO_DATA; // see RULE23
    end else if (pend.denied) begin
      d = `MMLP_DENY_DATA; // see RULE18
    end
    cpu_rsp_o = '0;
    crc_rsp_o = '0;
    dbg_rsp_o = '0;
    case (mmlp_host_type'(pend.rdata[1:0]))
      MMLP_HOST_CPU: cpu_rsp_o = '{pend.valid, pend.denied, pend.region, d};
      MMLP_HOST_CRC: crc_rsp_o = '{pend.valid, pend.denied, pend.region, d};
      MMLP_HOST_DBG: dbg_rsp_o = '{pend.valid, pend.denied, pend.region, d};
      default: cpu_rsp_o = '0;
    endcase
  end
endmodule
`default_nettype wire

// ===== testbench/mmlp_dbg_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmlp_dbg_model
  import mmlp_pkg::*;
(
  input wire logic clk_i,
  output var mmlp_req_type dbg_req_o,
  output var logic dbg_erase_o
);
  initial begin
    dbg_req_o = '0;
    dbg_erase_o = 1'b0;
  end
  // A released request shows inverted address and data so that stale values cannot pass.
  task automatic xfer(input logic wr, input logic fuse, input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    dbg_req_o <= '{1'b1, wr, fuse, addr, data};
    @(negedge clk_i);
    dbg_req_o <= '{1'b0, wr, fuse, ~addr, ~data};
  endtask
  task automatic erase();
    @(negedge clk_i);
    dbg_erase_o <= 1'b1;
    repeat (2) @(negedge clk_i);
    dbg_erase_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/mmlp_protect_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mmlp_protect_sva
  import mmlp_pkg::*;
#(
  parameter int SECTION_W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire mmlp_req_type cpu_req_i,
  input wire mmlp_req_type crc_req_i,
  input wire mmlp_req_type dbg_req_i,
  input wire logic dbg_erase_i,
  input wire logic [14:0] pmload_addr_i,
  input wire logic pmload_valid_i,
  input wire logic fetch_valid_i,
  input wire logic [7:0] lock_key_i,
  input wire logic [7:0] mem_rdata_i,
  input wire mmlp_mem_type mem_o,
  input wire logic [14:0] code_addr_o,
  input wire logic code_valid_o,
  input wire logic [1:0] ee_page_o,
  input wire mmlp_rsp_type cpu_rsp_o,
  input wire mmlp_rsp_type dbg_rsp_o,
  input wire logic erase_app_o,
  input wire logic erase_busy_o,
  input wire logic locked_o
);
  logic [2:0] up;
  // The reset synchroniser and key capture need a few edges; checks wait for them.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  end
  wire logic on = (up == 3'h7);
  wire logic cpu_rd = on && cpu_req_i.valid && !cpu_req_i.write;
  wire logic dbg_rd = on && dbg_req_i.valid && !dbg_req_i.write && !cpu_req_i.valid && !crc_req_i.valid;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_key_lock: assert property (on |-> locked_o == ($past(lock_key_i) != 8'hC5))
    else $error("lock flag does not follow the key");
  a_dbg_deny: assert property (
    dbg_rd && locked_o && dbg_req_i.addr >= 16'h3400 && dbg_req_i.addr <= 16'h3FFF
    |-> !mem_o.valid ##1 dbg_rsp_o.denied && dbg_rsp_o.rdata == 8'hFF)
    else $error("locked debug read reached memory");
  a_cpu_sram: assert property (
    cpu_rd && cpu_req_i.addr >= 16'h3400 && cpu_req_i.addr <= 16'h3FFF
    |-> mem_o.valid && mem_o.offset == cpu_req_i.addr - 16'h3400
    ##1 cpu_rsp_o.rdata == mem_rdata_i)
    else $error("cpu memory read mishandled");
  a_flash_win: assert property (
    cpu_rd && cpu_req_i.addr[15]
    |-> mem_o.region == MMLP_R_FLASH && mem_o.offset == {1'b0, cpu_req_i.addr[14:0]})
    else $error("flash window offset wrong");
  a_pm_load: assert property (pmload_valid_i && !fetch_valid_i |-> code_valid_o && code_addr_o == pmload_addr_i)
    else $error("program load address wrong");
  a_erase_once: assert property (on && dbg_erase_i && !erase_busy_o |-> erase_app_o ##1 !erase_app_o)
    else $error("erase pulse wrong");
  a_unmapped: assert property (
    cpu_rd && cpu_req_i.addr[15:14] == 2'b01
    |-> !mem_o.valid ##1 cpu_rsp_o.rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sig_ro: assert property (
    on && cpu_req_i.valid && cpu_req_i.write && cpu_req_i.addr[15:8] == 8'h11
    |-> !mem_o.valid)
    else $error("cpu write to signature passed");
  a_ee_page: assert property (mem_o.valid && mem_o.region == MMLP_R_EE |-> ee_page_o == mem_o.offset[7:6])
    else $error("eeprom page wrong");
  c_dbg_locked: cover property (dbg_rd && locked_o);
  c_erase: cover property (erase_app_o);
  c_cpu_rsp: cover property (cpu_rsp_o.valid);
endmodule
bind mmlp_protect mmlp_protect_sva #(.SECTION_W(SECTION_W)) i_mmlp_protect_sva (.*);
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import mmlp_pkg::*;
;
  typedef struct packed {logic [15:0] addr; logic ok; mmlp_region_type region; logic [15:0] offset;} mmlp_row_type;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  mmlp_req_type cpu_req_i = '0;
  mmlp_req_type crc_req_i = '0;
  mmlp_req_type dbg_req_i;
  logic dbg_erase_i;
  logic [14:0] fetch_addr_i = 15'h0000;
  logic fetch_valid_i = 1'b0;
  logic [14:0] pmload_addr_i = 15'h0000;
  logic pmload_valid_i = 1'b0;
  logic [7:0] lock_key_i = 8'h00;
  logic [7:0] boot_end_i = 8'h10;
  logic [7:0] app_end_i = 8'h90;
  logic [14:0] exec_pc_i = 15'h4000;
  logic [7:0] mem_rdata_i = 8'h00;
  mmlp_mem_type mem_o, seen_mem;
  mmlp_host_type mem_host_o, seen_host;
  logic seen_blk;
  logic [14:0] code_addr_o;
  logic code_valid_o, fetch_fault_o, erase_app_o, erase_busy_o, locked_o, section_block_o;
  logic [1:0] ee_page_o;
  mmlp_rsp_type cpu_rsp_o, crc_rsp_o, dbg_rsp_o;
  int miscompares = 0;
  int checked = 0;
  int erases = 0;
  mmlp_row_type rows [12] = '{'{16'h0000, 1'b1, MMLP_R_SIO, 16'h0000}, '{16'h003F, 1'b1, MMLP_R_SIO, 16'h003F},
    '{16'h0040, 1'b1, MMLP_R_XIO, 16'h0000}, '{16'h107F, 1'b1, MMLP_R_XIO, 16'h103F},
    '{16'h1100, 1'b1, MMLP_R_SIG, 16'h0000}, '{16'h1289, 1'b1, MMLP_R_FUSE, 16'h0009},
    '{16'h1300, 1'b1, MMLP_R_UROW, 16'h0000}, '{16'h14FF, 1'b1, MMLP_R_EE, 16'h00FF},
    '{16'h3FFF, 1'b1, MMLP_R_SRAM, 16'h0BFF}, '{16'h8000, 1'b1, MMLP_R_FLASH, 16'h0000},
    '{16'hFFFF, 1'b1, MMLP_R_FLASH, 16'h7FFF}, '{16'h4000, 1'b0, MMLP_R_NONE, 16'h0000}};
  mmlp_protect i_mmlp_protect (.*);
  mmlp_dbg_model i_mmlp_dbg_model (.clk_i(clk_i), .dbg_req_o(dbg_req_i), .dbg_erase_o(dbg_erase_i));
  always #5 clk_i = ~clk_i;
  // The combinational grant is captured at the edge that takes the request.
  always @(posedge clk_i) begin
    seen_mem <= mem_o;
    seen_host <= mem_host_o;
    seen_blk <= section_block_o;
    if (erase_app_o === 1'b1) erases++;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cpu(input logic wr, input logic [15:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    cpu_req_i <= '{1'b1, wr, 1'b0, addr, data};
    mem_rdata_i <= data;
    @(negedge clk_i);
    cpu_req_i <= '{1'b0, wr, 1'b0, ~addr, ~data};
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    chk("locked in reset", locked_o, 1'b1);
    @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    foreach (rows[i]) begin
      cpu(1'b0, rows[i].addr, 8'hA0 + 8'(i));
      chk("grant", seen_mem.valid, rows[i].ok);
      if (rows[i].ok) chk("region", {seen_mem.region, seen_mem.offset}, {rows[i].region, rows[i].offset});
      chk("cpu data", cpu_rsp_o.rdata, rows[i].ok ? 8'hA0 + 8'(i) : 8'h00);
    end
    $display("address map test done");
    mem_rdata_i = 8'h3C;
    i_mmlp_dbg_model.xfer(1'b0, 1'b0, 16'h3400, 8'h00);
    chk("locked read", {seen_mem.valid, dbg_rsp_o.denied, dbg_rsp_o.rdata}, {2'b01, 8'hFF});
    i_mmlp_dbg_model.xfer(1'b1, 1'b1, 16'h1300, 8'h77);
    chk("locked user write", {seen_mem.valid, seen_host}, {1'b1, MMLP_HOST_DBG});
    i_mmlp_dbg_model.xfer(1'b0, 1'b0, 16'h1300, 8'h00);
    chk("locked user read", dbg_rsp_o.rdata, 8'hFF);
    lock_key_i = 8'hC4;
    repeat (2) @(negedge clk_i);
    chk("near key", locked_o, 1'b1);
    lock_key_i = 8'hC5;
    repeat (2) @(negedge clk_i);
    chk("valid key", locked_o, 1'b0);
    i_mmlp_dbg_model.xfer(1'b0, 1'b0, 16'h1305, 8'h00);
    chk("open user read", {seen_mem.offset, dbg_rsp_o.rdata}, {16'h0005, 8'h3C});
    i_mmlp_dbg_model.xfer(1'b1, 1'b0, 16'h1281, 8'h12);
    chk("debug fuse write", {seen_mem.valid, seen_mem.write, seen_mem.wdata}, {2'b11, 8'h12});
    i_mmlp_dbg_model.xfer(1'b1, 1'b0, 16'h1100, 8'h12);
    chk("debug sig write", seen_mem.valid, 1'b0);
    cpu(1'b1, 16'h1280, 8'h01);
    chk("cpu fuse write", seen_mem.valid, 1'b0);
    cpu(1'b1, 16'h1100, 8'h01);
    chk("cpu sig write", seen_mem.valid, 1'b0);
    cpu(1'b1, 16'h8000, 8'h01);
    chk("cross section write", {seen_mem.valid, seen_blk}, 2'b01);
    @(negedge clk_i);
    crc_req_i <= '{1'b1, 1'b0, 1'b0, 16'h1400, 8'h00};
    @(negedge clk_i);
    crc_req_i <= '0;
    chk("crc read", {crc_rsp_o.valid, seen_host}, {1'b1, MMLP_HOST_CRC});
    pmload_valid_i = 1'b1;
    pmload_addr_i = 15'h7FFF;
    fetch_addr_i = 15'h3400;
    #1 chk("code load", {code_valid_o, code_addr_o, fetch_fault_o}, {1'b1, 15'h7FFF, 1'b0});
    pmload_valid_i = 1'b0;
    i_mmlp_dbg_model.erase();
    chk("erase busy", erase_busy_o, 1'b1);
    @(negedge clk_i);
    chk("erase pulses", erases, 1);
    resetn_i = 1'b0;
    #1 chk("locked in second reset", locked_o, 1'b1);
    repeat (3) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("open after reset", locked_o, 1'b0);
    $display("protection tests done");
    close_out();
  end
endmodule
`default_nettype wire
